// ===== rtl/iec_pkg.sv
package iec_pkg;
  // Channel count and widths
  localparam int IEC_NUM_CH    = 3;
  localparam int IEC_CNT_W     = 32;
  localparam int IEC_IDX_W     = 2;
  localparam int IEC_FMT_W     = 2;
  localparam int IEC_SYNC_LEN  = 2;
  // Activity hold time in cycles
  localparam int IEC_ACT_HOLD  = 4096;
  localparam int IEC_ACT_W     = 13;

  // Line signal formats
  typedef enum logic [1:0] {
    IEC_FMT_SE_HTL = 2'h0,
    IEC_FMT_D_HTL  = 2'h1,
    IEC_FMT_RS422  = 2'h2,
    IEC_FMT_TTL    = 2'h3
  } iec_fmt_t;

  localparam iec_fmt_t IEC_FMT_RESET = IEC_FMT_SE_HTL;
  localparam logic [IEC_CNT_W-1:0] IEC_CNT_ZERO = 32'h0000_0000;
  localparam logic [IEC_CNT_W-1:0] IEC_CNT_ONE  = 32'h0000_0001;

  // Host command group
  typedef struct packed {
    logic                 read_cmd;
    logic                 clear_cmd;
    logic                 fmt_wr_cmd;
    logic [IEC_IDX_W-1:0] index;
    iec_fmt_t             fmt;
  } iec_cmd_t;

  // Phase pins of one channel
  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } iec_phase_t;
endpackage

// ===== rtl/iec_chan.sv
`timescale 1ns/10ps
`default_nettype none
module iec_chan
  import iec_pkg::*;
#(
  parameter int CNT_W    = IEC_CNT_W,
  parameter int ACT_HOLD = IEC_ACT_HOLD
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // Phase pins
  input  wire iec_phase_t       phase,
  // Control
  input  wire logic             clear,
  input  wire logic             fault_in,
  // State
  output logic signed [CNT_W-1:0] count,
  output logic                  active,
  output logic                  fault
);
  // Whole channel state
  typedef struct packed {
    logic [IEC_SYNC_LEN-1:0] a_sync;
    logic [IEC_SYNC_LEN-1:0] b_sync;
    logic                    a_last;
    logic [CNT_W-1:0]        cnt;
    logic [IEC_ACT_W-1:0]    act_cnt;
    logic                    flt;
  } iec_chan_state_t;

  iec_chan_state_t st_reg;   // Registered state
  iec_chan_state_t st_next;  // Next state
  logic            a_rise;   // Counting event
  logic            a_s;      // Synced A
  logic            b_s;      // Synced B

  assign a_s    = st_reg.a_sync[IEC_SYNC_LEN-1];
  assign b_s    = st_reg.b_sync[IEC_SYNC_LEN-1];
  // [R2] A rising edge
  assign a_rise = a_s & ~st_reg.a_last;

  // Next state
  always_comb begin
    st_next = st_reg;
    // [R13] Two stage sync
    st_next.a_sync = {st_reg.a_sync[IEC_SYNC_LEN-2:0], phase.a};
    st_next.b_sync = {st_reg.b_sync[IEC_SYNC_LEN-2:0], phase.b};
    st_next.a_last = a_s;
    // [R8] Index ignored
    if (clear) begin
      // [R7] Zero on clear
      st_next.cnt = IEC_CNT_ZERO;
    end else if (a_rise) begin
      // [R3] Direction from B
      if (!b_s) begin
        // [R4] Clockwise increment
        st_next.cnt = st_reg.cnt + IEC_CNT_ONE;
      end else begin
        // [R4] Counterclockwise decrement
        st_next.cnt = st_reg.cnt - IEC_CNT_ONE;
      end
    end
    // [R12] Activity retrigger
    if (a_rise) begin
      st_next.act_cnt = IEC_ACT_W'(ACT_HOLD);
    end else if (st_reg.act_cnt != '0) begin
      st_next.act_cnt = st_reg.act_cnt - 1'b1;
    end
    // [R12] Sticky fault, set wins
    if (fault_in) begin
      st_next.flt = 1'b1;
    end else if (clear) begin
      st_next.flt = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // [R14] Reset state
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // [R5] Signed 32-bit position
  assign count  = st_reg.cnt;
  assign active = (st_reg.act_cnt != '0);
  assign fault  = st_reg.flt;

  // Edge to count relation
  property p_cw_step;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && a_rise && !b_s && !clear) |=> (st_reg.cnt == $past(st_reg.cnt) + IEC_CNT_ONE);
  endproperty
  a_cw_step: assert property (p_cw_step) else $error("cw step wrong"); // [R4]

  property p_ccw_step;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && a_rise && b_s && !clear) |=> (st_reg.cnt == $past(st_reg.cnt) - IEC_CNT_ONE);
  endproperty
  a_ccw_step: assert property (p_ccw_step) else $error("ccw step wrong"); // [R3]

  property p_hold;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && !a_rise && !clear) |=> $stable(st_reg.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without edge"); // [R2]

  property p_clear;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && clear) |=> (st_reg.cnt == IEC_CNT_ZERO);
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed"); // [R7]

  property p_sync;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && $past(clk_en) && $past(clk_en, 2) && a_rise) |-> $past(phase.a, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("edge not from synced pin"); // [R13]

  property p_act;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && a_rise) |=> active;
  endproperty
  a_act: assert property (p_act) else $error("activity not raised"); // [R12]

  property p_fault;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && fault_in) |=> fault;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not latched"); // [R12]

  c_cw: cover property (@(posedge sys_clk) disable iff (rst) a_rise && !b_s);
  c_ccw: cover property (@(posedge sys_clk) disable iff (rst) a_rise && b_s);
  c_clr: cover property (@(posedge sys_clk) disable iff (rst) clear && a_rise);
endmodule
`default_nettype wire

// ===== rtl/iec_top.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [R1] Three independent channels selected by index
// [R2] Count on rising edges of A
// [R3] Direction from A/B relative phase
// [R4] Clockwise plus one, counterclockwise minus one
// [R5] Signed 32-bit position per channel
// [R6] Host reads selected channel count anytime
// [R7] Host clear zeroes selected channel only
// [R8] Index Z input has no effect
// [R9] No encoder fault Y input exists
// [R10] Per-channel line format, host written
// [R11] Termination output when format RS-422
// [R12] Activity and fault indications per channel
// [R13] Two-stage synchronisers before edge detection
// [R14] Reset: zero counts, SE HTL, flags clear
module iec_top
  import iec_pkg::*;
#(
  parameter int NUM_CH   = IEC_NUM_CH,
  parameter int CNT_W    = IEC_CNT_W,
  parameter int ACT_HOLD = IEC_ACT_HOLD
) (
  // Clock, reset, enable
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // Encoder pins
  input  wire iec_phase_t [NUM_CH-1:0] phase,
  // Channel fault sources from line receiver
  input  wire logic [NUM_CH-1:0]    line_fault,
  // Host commands
  input  wire iec_cmd_t             cmd,
  // Host answers
  output logic signed [CNT_W-1:0]   read_data,
  output logic                      read_valid,
  // Indications
  output iec_fmt_t [NUM_CH-1:0]     line_format,
  output logic [NUM_CH-1:0]         term_on,
  output logic [NUM_CH-1:0]         activity,
  output logic [NUM_CH-1:0]         fault
);
  // Whole top state
  typedef struct packed {
    logic [CNT_W-1:0]      rdata;
    logic                  rvalid;
    iec_fmt_t [NUM_CH-1:0] fmt;
    logic [NUM_CH-1:0]     term;
    logic [NUM_CH-1:0]     act;
    logic [NUM_CH-1:0]     flt;
  } iec_top_state_t;

  iec_top_state_t          st_reg;   // Registered state
  iec_top_state_t          st_next;  // Next state
  logic [NUM_CH-1:0]       clr_sel;  // Per-channel clear
  logic [CNT_W-1:0]        ch_cnt [NUM_CH];  // Channel counts
  logic [NUM_CH-1:0]       ch_act;   // Channel activity
  logic [NUM_CH-1:0]       ch_flt;   // Channel fault

  // [R9] Faults come only from line receiver
  // [R1] One channel instance each
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign clr_sel[i] = cmd.clear_cmd && (cmd.index == IEC_IDX_W'(i));
    iec_chan #(
      .CNT_W    (CNT_W),
      .ACT_HOLD (ACT_HOLD)
    ) u_chan (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .phase    (phase[i]),
      .clear    (clr_sel[i]),
      .fault_in (line_fault[i]),
      .count    (ch_cnt[i]),
      .active   (ch_act[i]),
      .fault    (ch_flt[i])
    );
  end

  // Next state
  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = 1'b0;
    st_next.act    = ch_act;
    st_next.flt    = ch_flt;
    // Index three selects no channel, read dropped
    // [R6] Read selected count
    if (cmd.read_cmd && (cmd.index < IEC_IDX_W'(NUM_CH))) begin
      st_next.rdata  = ch_cnt[cmd.index];
      st_next.rvalid = 1'b1;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      // [R10] Format write
      if (cmd.fmt_wr_cmd && (cmd.index == IEC_IDX_W'(i))) begin
        st_next.fmt[i] = cmd.fmt;
      end
      // Built from next format so both outputs switch together
      // [R11] Termination for RS-422
      st_next.term[i] = (st_next.fmt[i] == IEC_FMT_RS422);
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // [R14] Reset formats and outputs
      st_reg <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        st_reg.fmt[i] <= IEC_FMT_RESET;
      end
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign read_data   = st_reg.rdata;
  assign read_valid  = st_reg.rvalid;
  assign line_format = st_reg.fmt;
  assign term_on     = st_reg.term;
  assign activity    = st_reg.act;
  assign fault       = st_reg.flt;

  // Checks on the host side
  // [R6] Read of channel zero
  property p_read;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cmd.read_cmd && cmd.index == 2'h0) |=> (read_valid && read_data == $past(ch_cnt[0]));
  endproperty
  a_read: assert property (p_read) else $error("read data wrong"); // [R6]

  // [R11] Termination of channel zero
  property p_term;
    @(posedge sys_clk) disable iff (rst)
      term_on[0] == (line_format[0] == IEC_FMT_RS422);
  endproperty
  a_term: assert property (p_term) else $error("termination mismatch"); // [R11]

  // [R10] Format write on channel one
  property p_fmt;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cmd.fmt_wr_cmd && cmd.index == 2'h1) |=> (line_format[1] == $past(cmd.fmt));
  endproperty
  a_fmt: assert property (p_fmt) else $error("format not written"); // [R10]

  // [R6] Read of channel one
  property p_read1;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cmd.read_cmd && cmd.index == 2'h1) |=> (read_valid && read_data == $past(ch_cnt[1]));
  endproperty
  a_read1: assert property (p_read1) else $error("read data wrong on channel one"); // [R6]

  // [R6] Read of channel two
  property p_read2;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cmd.read_cmd && cmd.index == 2'h2) |=> (read_valid && read_data == $past(ch_cnt[2]));
  endproperty
  a_read2: assert property (p_read2) else $error("read data wrong on channel two"); // [R6]

  // [R6] No read, no valid pulse
  property p_read_idle;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && !cmd.read_cmd) |=> !read_valid;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("valid without read"); // [R6]

  // [R1] Index three reads nothing
  property p_read_bad;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cmd.read_cmd && cmd.index == 2'h3) |=> !read_valid;
  endproperty
  a_read_bad: assert property (p_read_bad) else $error("read of missing channel answered"); // [R1]

  // [R6] Read data holds between reads
  property p_rdata_hold;
    @(posedge sys_clk) disable iff (rst)
      !(clk_en && cmd.read_cmd) |=> $stable(read_data);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read"); // [R6]

  // [R10] Format holds without write
  property p_fmt_hold;
    @(posedge sys_clk) disable iff (rst)
      !(clk_en && cmd.fmt_wr_cmd) |=> $stable(line_format);
  endproperty
  a_fmt_hold: assert property (p_fmt_hold) else $error("format moved without write"); // [R10]

  // [R11] Termination of channels one, two
  property p_term_rest;
    @(posedge sys_clk) disable iff (rst)
      (term_on[1] == (line_format[1] == IEC_FMT_RS422)) && (term_on[2] == (line_format[2] == IEC_FMT_RS422));
  endproperty
  a_term_rest: assert property (p_term_rest) else $error("termination mismatch on upper channels"); // [R11]

  // [R7] Clear reaches channel two
  property p_clr_ch2;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && cmd.clear_cmd && cmd.index == 2'h2) |=> (ch_cnt[2] == IEC_CNT_ZERO);
  endproperty
  a_clr_ch2: assert property (p_clr_ch2) else $error("clear missed channel two"); // [R7]

  // [R1] Index three clears nothing
  property p_clr_bad;
    @(posedge sys_clk) disable iff (rst)
      (cmd.clear_cmd && cmd.index == 2'h3) |-> (clr_sel == '0);
  endproperty
  a_clr_bad: assert property (p_clr_bad) else $error("clear of missing channel decoded"); // [R1]

  // [R12] Activity output follows channel
  property p_act_mirror;
    @(posedge sys_clk) disable iff (rst)
      clk_en |=> (activity == $past(ch_act));
  endproperty
  a_act_mirror: assert property (p_act_mirror) else $error("activity output lags wrongly"); // [R12]

  // [R12] Fault output follows channel
  property p_flt_mirror;
    @(posedge sys_clk) disable iff (rst)
      clk_en |=> (fault == $past(ch_flt));
  endproperty
  a_flt_mirror: assert property (p_flt_mirror) else $error("fault output lags wrongly"); // [R12]

  c_read: cover property (@(posedge sys_clk) disable iff (rst) read_valid);
  c_term: cover property (@(posedge sys_clk) disable iff (rst) term_on[2]);
endmodule
`default_nettype wire

// ===== verification/iec_enc_model.sv
`timescale 1ns/10ps
`default_nettype none
// Three-channel quadrature shaft encoder
module iec_enc_model
  import iec_pkg::*;
(
  // Pacing clock
  input  wire logic        sys_clk,
  // Encoder pins
  output var iec_phase_t [2:0] phase
);
  // Pins idle low
  initial phase = '0;

  // Quarter steps three cycles apart, longer than the synchroniser
  // A rise with B low is clockwise
  task automatic turn(input int ch, input bit cw, input int n);
    logic [1:0] s [4];
    if (cw) begin
      s = '{2'h2, 2'h3, 2'h1, 2'h0};
    end else begin
      s = '{2'h1, 2'h3, 2'h2, 2'h0};
    end
    repeat (n) begin
      for (int i = 0; i < 4; i++) begin
        repeat (3) @(negedge sys_clk);
        {phase[ch].a, phase[ch].b} = s[i];
      end
    end
  endtask

  // Index pulse only, no phase motion
  task automatic index_pulse(input int ch);
    repeat (3) @(negedge sys_clk);
    phase[ch].z = 1'b1;
    repeat (3) @(negedge sys_clk);
    phase[ch].z = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verification/test_iec_top.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the encoder counter
module test_iec_top
  import iec_pkg::*;
();
  // Short activity hold for simulation
  localparam int HOLD = 32;
  logic               sys_clk;
  logic               rst;
  logic               clk_en;
  iec_phase_t [2:0]   phase;
  logic [2:0]         line_fault;
  iec_cmd_t           cmd;
  logic signed [31:0] read_data;
  logic               read_valid;
  iec_fmt_t [2:0]     line_format;
  logic [2:0]         term_on;
  logic [2:0]         activity;
  logic [2:0]         fault;
  int                 errors;
  int                 tests_run;
  int                 cyc;

  iec_enc_model model (.sys_clk(sys_clk), .phase(phase));

  iec_top #(.ACT_HOLD(HOLD)) DUT (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .phase(phase),
    .line_fault(line_fault), .cmd(cmd), .read_data(read_data),
    .read_valid(read_valid), .line_format(line_format),
    .term_on(term_on), .activity(activity), .fault(fault)
  );

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One-cycle host command, op bits are read, clear, format write
  task automatic issue(input logic [2:0] op, input int ch, input iec_fmt_t f);
    @(negedge sys_clk);
    cmd = iec_cmd_t'({op, ch[1:0], f});
    @(negedge sys_clk);
    cmd = '0;
  endtask

  // Read a channel and compare the count
  task automatic rd(input int ch, input logic [31:0] exp);
    issue(3'h4, ch, IEC_FMT_SE_HTL);
    for (int i = 0; i < 3 && read_valid !== 1'b1; i++) @(negedge sys_clk);
    chk(read_valid, 32'h1);
    chk(read_data, exp);
  endtask

  // Verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    line_fault = '0;
    cmd = '0;
    errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    for (int c = 0; c < 3; c++) rd(c, 32'h0);
    chk({line_format, term_on, activity, fault}, 32'h0);
    $display("test reset done");
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 3; c++) issue(3'h1, c, iec_fmt_t'(f));
      chk(line_format, {3{f[1:0]}});
      chk(term_on, {3{f == 2}});
    end
    issue(3'h1, 3, IEC_FMT_SE_HTL);
    chk(line_format, {3{2'h3}});
    issue(3'h1, 0, IEC_FMT_RS422);
    chk(term_on, 32'h1);
    $display("test format done");
    model.turn(0, 1'b1, 5);
    chk(activity, 32'h1);
    model.turn(1, 1'b0, 3);
    model.index_pulse(2);
    rd(0, 32'h5);
    rd(1, 32'hFFFF_FFFD);
    rd(2, 32'h0);
    repeat (HOLD + 8) @(negedge sys_clk);
    chk(activity, 32'h0);
    issue(3'h2, 1, IEC_FMT_SE_HTL);
    rd(1, 32'h0);
    rd(0, 32'h5);
    // Index three selects nothing
    issue(3'h2, 3, IEC_FMT_SE_HTL);
    rd(0, 32'h5);
    issue(3'h4, 3, IEC_FMT_SE_HTL);
    chk(read_valid, 32'h0);
    $display("test count done");
    line_fault = 3'h4;
    repeat (3) @(negedge sys_clk);
    line_fault = 3'h0;
    repeat (3) @(negedge sys_clk);
    chk(fault, 32'h4);
    issue(3'h2, 2, IEC_FMT_SE_HTL);
    // Fault output trails the channel by one register
    @(negedge sys_clk);
    chk(fault, 32'h0);
    // Fault event and clear together, the fault stays
    line_fault = 3'h2;
    issue(3'h2, 1, IEC_FMT_SE_HTL);
    line_fault = 3'h0;
    repeat (2) @(negedge sys_clk);
    chk(fault, 32'h2);
    clk_en = 1'b0;
    model.turn(0, 1'b1, 1);
    clk_en = 1'b1;
    rd(0, 32'h5);
    $display("test fault done");
    // Reset in mid-run restores defaults
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    rd(0, 32'h0);
    chk({line_format, term_on, fault}, 32'h0);
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
